// [logic/efc_frame_ctrl.sv]
// Frame composition controller: registers, frame builder and serial port.
// Assumes acquisition data on ref_clk and a host driving sclk, cs_n and mosi.
module efc_frame_ctrl #(
    parameter longint RATE_2K_CYC   = efc_pkg::RATE_2K_CYC_DEF,
    parameter longint RATE_SLOW_CYC = efc_pkg::RATE_SLOW_CYC_DEF
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              mosi,
    input  efc_pkg::efc_acq_s      acq,
    output logic                   sdo,
    output efc_pkg::efc_filt_s     filt_cfg,
    output logic [23:0]            calibration_converter_ctrl_word,
    output logic                   electrode_fmt
);
    import efc_pkg::*;

    if (RATE_2K_CYC < 2 || RATE_SLOW_CYC < 2 || RATE_SLOW_CYC > 64'd4194303) begin : g_chk
        $error("efc_frame_ctrl: frame period out of range");
    end

    // ==================================================
    // Serial domain: bit counter and receive shifter
    logic        spi_clr_n_w;
    logic [4:0]  bit_cnt_ff;
    logic [30:0] rx_sh_ff;
    logic        slot_end_w;
    logic [31:0] rx_word_w;
    logic        rx_write_w;
    logic        cal_start_w;
    logic [31:0] wr_word_ff;
    logic        wr_tgl_ff;
    logic [2:0]  cal_cnt_ff;

    // Clock stands still between selects, so the select clears the counter
    assign spi_clr_n_w = reset_n & ~cs_n;
    assign slot_end_w  = bit_cnt_ff == 5'h1F;
    assign rx_word_w   = {rx_sh_ff, mosi};
    assign rx_write_w  = slot_end_w & rx_word_w[CMD_WRITE_BIT];
    assign cal_start_w = rx_write_w & (rx_word_w[30:CMD_ADDR_LSB] == REG_CALIBRATION_CONVERTER_CTRL_OFS);

    always_ff @(posedge sclk or negedge spi_clr_n_w) begin
        if (!spi_clr_n_w) begin
            bit_cnt_ff <= 5'h00;
            rx_sh_ff   <= 31'h00000000;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            rx_sh_ff   <= rx_word_w[30:0];
        end
    end

    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_word_ff <= 32'h00000000;
            wr_tgl_ff  <= 1'b0;
            cal_cnt_ff <= 3'h0;
        end else begin
            if (rx_write_w) begin
                wr_word_ff <= rx_word_w;
            end
            if (cal_start_w) begin
                cal_cnt_ff <= CAL_TAIL_SCLK;
            end else if (cal_cnt_ff != 3'h0) begin
                cal_cnt_ff <= cal_cnt_ff - 3'h1;
            end
            if ((rx_write_w && !cal_start_w) || cal_cnt_ff == 3'h1) begin
                wr_tgl_ff <= ~wr_tgl_ff;
            end
        end
    end

    // ==================================================
    // Core domain: register writes arrive as a toggle
    logic [2:0]  wr_s_ff;
    logic        wr_ev_w;
    logic [6:0]  wr_addr_w;
    logic [23:0] frm_ff;
    logic [23:0] filt_ff;
    logic [23:0] cal_ff;

    // Word stays put for 32 serial clocks, far longer than the sync delay
    assign wr_ev_w   = wr_s_ff[2] ^ wr_s_ff[1];
    assign wr_addr_w = wr_word_ff[30:CMD_ADDR_LSB];

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_s_ff <= 3'h0;
            frm_ff  <= FRAME_RST;
            filt_ff <= FILT_RST;
            cal_ff  <= CALIBRATION_CONVERTER_CTRL_RST;
        end else begin
            wr_s_ff <= {wr_s_ff[1:0], wr_tgl_ff};
            if (wr_ev_w && wr_addr_w == REG_FRAME_OFS) begin
                frm_ff <= wr_word_ff[23:0];
            end
            if (wr_ev_w && wr_addr_w == REG_FILT_OFS) begin
                filt_ff <= wr_word_ff[23:0];
            end
            if (wr_ev_w && wr_addr_w == REG_CALIBRATION_CONVERTER_CTRL_OFS) begin
                cal_ff <= wr_word_ff[23:0];
            end
        end
    end

    // ==================================================
    // Core domain: configuration outputs
    efc_rate_e rate_w;
    logic      fmt_ok_w;
    efc_filt_s filt_cfg_ff;
    logic      electrode_fmt_ff;

    assign rate_w   = efc_rate_e'(frm_ff[FRM_RATE_LSB+:2]);
    assign fmt_ok_w = (rate_w == RATE_2K) || (rate_w == RATE_16K);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_cfg_ff      <= '0;
            electrode_fmt_ff <= 1'b0;
        end else begin
            filt_cfg_ff.master_notch_insert   <= filt_ff[FILT_MASTER_NOTCH];
            filt_cfg_ff.notch_bypass          <= filt_ff[FILT_NOTCH_BYPASS];
            filt_cfg_ff.lowpass_corner_select <= filt_ff[FILT_LPF_LSB+:2];
            // Lead words not served at the fast and slow rates
            electrode_fmt_ff <= frm_ff[FRM_FORMAT] | ~fmt_ok_w;
        end
    end

    assign filt_cfg      = filt_cfg_ff;
    assign calibration_converter_ctrl_word   = cal_ff;
    assign electrode_fmt = electrode_fmt_ff;

    // ==================================================
    // Core domain: frame timer and skip decimation
    logic [21:0] rate_cnt_ff;
    logic [21:0] period_w;
    logic        tick_w;
    logic [1:0]  skip_cnt_ff;
    logic [1:0]  skip_mask_w;
    logic        emit_w;

    assign period_w = (rate_w == RATE_2K)  ? 22'(RATE_2K_CYC) :
                      (rate_w == RATE_16K) ? 22'(RATE_16K_CYC) :
                      (rate_w == RATE_128K) ? 22'(RATE_128K_CYC) : 22'(RATE_SLOW_CYC);
    assign tick_w      = rate_cnt_ff >= period_w - 22'h000001;
    assign skip_mask_w = frm_ff[FRM_SKIP_LSB+1] ? 2'h3 : {1'b0, frm_ff[FRM_SKIP_LSB]};
    assign emit_w      = tick_w && ((skip_cnt_ff & skip_mask_w) == 2'h0);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rate_cnt_ff <= 22'h000000;
            skip_cnt_ff <= 2'h0;
        end else begin
            rate_cnt_ff <= tick_w ? 22'h000000 : rate_cnt_ff + 22'h000001;
            skip_cnt_ff <= tick_w ? skip_cnt_ff + 2'h1 : skip_cnt_ff;
        end
    end

    // ==================================================
    // Core domain: frame composition
    logic [31:0] slot_w [FRAME_WORDS];
    logic [9:0]  inc_w;
    logic [31:0] packed_w [FRAME_WORDS];
    logic [3:0]  cnt_w;
    logic        auto_w;

    assign auto_w    = frm_ff[FRM_AUTO_DROP];
    assign slot_w[0] = {1'b1, 1'b0, acq.pace_flag, acq.resp_flag, acq.eoff_flag, 27'h0000000};
    // Channel data passes raw; nothing masks an electrode that fell off
    assign slot_w[1] = {WA_CH1, acq.chan[0]};
    assign slot_w[2] = {WA_CH1 + 8'h01, acq.chan[1]};
    assign slot_w[3] = {WA_CH1 + 8'h02, acq.chan[2]};
    assign slot_w[4] = {WA_PACE, acq.pace};
    assign slot_w[5] = {WA_RESPM, acq.resp_mag};
    assign slot_w[6] = {WA_RESPP, acq.resp_phase};
    assign slot_w[7] = {WA_EOFF, acq.eoff};
    assign slot_w[8] = {WA_PIN, acq.pin_state};
    assign slot_w[9] = {WA_CHK, 24'h000000};

    assign inc_w[0] = 1'b1;
    assign inc_w[1] = ~frm_ff[FRM_CH1_EXCL];
    assign inc_w[2] = ~frm_ff[FRM_CH2_EXCL];
    assign inc_w[3] = ~frm_ff[FRM_CH3_EXCL];
    assign inc_w[4] = ~frm_ff[FRM_PACE_EXCL] & ~(auto_w & ~acq.pace_flag);
    assign inc_w[5] = ~frm_ff[FRM_RESPM_EXCL] & ~(auto_w & ~acq.resp_flag);
    assign inc_w[6] = ~frm_ff[FRM_RESPP_EXCL];
    assign inc_w[7] = ~frm_ff[FRM_EOFF_EXCL] & ~(auto_w & ~acq.eoff_flag);
    assign inc_w[8] = ~frm_ff[FRM_PIN_EXCL];
    assign inc_w[9] = ~frm_ff[FRM_CHK_EXCL];

    // Check word is the XOR of the data fields sent before it
    always_comb begin
        int          k;
        logic [23:0] chk;
        k   = 0;
        chk = 24'h000000;
        for (int i = 0; i < FRAME_WORDS; i++) begin
            packed_w[i] = 32'h00000000;
        end
        for (int i = 0; i < FRAME_WORDS; i++) begin
            if (inc_w[i]) begin
                packed_w[k] = (i == FRAME_WORDS - 1) ? {WA_CHK, chk} : slot_w[i];
                chk         = chk ^ slot_w[i][23:0];
                k           = k + 1;
            end
        end
        cnt_w = 4'(k);
    end

    // ==================================================
    // Core domain: frame buffer handed over by toggle
    logic [31:0] buf_ff [FRAME_WORDS];
    logic [3:0]  frame_cnt_ff;
    logic        req_tgl_ff;
    logic [1:0]  ack_s_ff;
    logic        ack_tgl_ff;
    logic        load_w;

    // A frame due while the port still reads the last one is dropped
    assign load_w = emit_w && (req_tgl_ff == ack_s_ff[1]);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < FRAME_WORDS; i++) begin
                buf_ff[i] <= 32'h00000000;
            end
            frame_cnt_ff <= 4'h1;
            req_tgl_ff   <= 1'b0;
            ack_s_ff     <= 2'h0;
        end else begin
            ack_s_ff <= {ack_s_ff[0], ack_tgl_ff};
            if (load_w) begin
                for (int i = 0; i < FRAME_WORDS; i++) begin
                    buf_ff[i] <= packed_w[i];
                end
                frame_cnt_ff <= cnt_w;
                req_tgl_ff   <= ~req_tgl_ff;
            end
        end
    end

    // ==================================================
    // Serial domain: frame transmit
    logic [1:0]  req_s_ff;
    logic [1:0]  rpt_s_ff;
    logic [3:0]  idx_ff;
    logic        live_ff;
    logic [3:0]  last_cnt_ff;
    logic [31:0] tx_sh_ff;
    logic        new_w;
    logic        hdr_w;
    logic        start_w;
    logic        stay_w;
    logic [3:0]  cur_cnt_w;
    logic        wrap_w;
    logic [31:0] tx_next_w;

    assign new_w     = req_s_ff[1] != ack_tgl_ff;
    assign hdr_w     = idx_ff == 4'h0;
    assign start_w   = hdr_w & new_w;
    assign stay_w    = hdr_w & ~start_w & (rpt_s_ff[1] | (last_cnt_ff <= 4'h1));
    assign cur_cnt_w = start_w ? frame_cnt_ff : last_cnt_ff;
    assign wrap_w    = stay_w | (idx_ff == cur_cnt_w - 4'h1);
    // Without repeat a missing frame still goes out at full length, header not ready
    assign tx_next_w = start_w ? buf_ff[0] :
                       hdr_w   ? HDR_NOT_READY :
                       live_ff ? buf_ff[idx_ff] : 32'h00000000;

    always_ff @(posedge sclk or negedge reset_n) begin
        if (!reset_n) begin
            req_s_ff    <= 2'h0;
            rpt_s_ff    <= 2'h0;
            idx_ff      <= 4'h0;
            live_ff     <= 1'b0;
            last_cnt_ff <= 4'h1;
            ack_tgl_ff  <= 1'b0;
            tx_sh_ff    <= 32'h00000000;
        end else begin
            req_s_ff <= {req_s_ff[0], req_tgl_ff};
            rpt_s_ff <= {rpt_s_ff[0], frm_ff[FRM_HDR_RPT]};
            if (slot_end_w && !cs_n) begin
                tx_sh_ff <= tx_next_w;
                idx_ff   <= wrap_w ? 4'h0 : idx_ff + 4'h1;
                live_ff  <= hdr_w ? start_w : live_ff;
                if (start_w) begin
                    last_cnt_ff <= frame_cnt_ff;
                end
                if (wrap_w && (start_w || (live_ff && !hdr_w))) begin
                    ack_tgl_ff <= ~ack_tgl_ff;
                end
            end else begin
                tx_sh_ff <= {tx_sh_ff[30:0], 1'b0};
            end
        end
    end

    assign sdo = tx_sh_ff[31];

    // ==================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_frame_reset_val: assert property ($rose(reset_n) |-> frm_ff == FRAME_RST)
        else $error("frame register reset value wrong");
    a_chan_excl_gap: assert property (load_w && frm_ff[FRM_CH1_EXCL] |=> buf_ff[1][31:24] != WA_CH1)
        else $error("excluded channel word present");
    a_fixed_len: assert property (load_w && !auto_w |=>
        frame_cnt_ff == 4'(1 + $countones(~{$past(frm_ff[23:21]), $past(frm_ff[14:9])})))
        else $error("fixed frame length wrong");
    a_auto_drop_len: assert property (load_w && auto_w && !acq.pace_flag && !acq.resp_flag && !acq.eoff_flag
        |=> frame_cnt_ff == 4'(1 + $countones(~{$past(frm_ff[23:21]), $past(frm_ff[12]), $past(frm_ff[10:9])})))
        else $error("auto drop length wrong");
    a_hdr_first: assert property (load_w |=> buf_ff[0][HDR_MARK_BIT] && !buf_ff[0][HDR_NRDY_BIT])
        else $error("frame does not start with ready header");
    a_fast_period: assert property (tick_w && rate_w == RATE_128K && $stable(frm_ff) |=> (!tick_w) [*8])
        else $error("fast frame period too short");
    a_skip_four: assert property (emit_w && frm_ff[FRM_SKIP_LSB+1] |-> skip_cnt_ff == 2'h0)
        else $error("skip four let a frame through");
    a_fmt_forced: assert property (!fmt_ok_w |=> electrode_fmt)
        else $error("lead format at unsupported rate");
    a_filter_out: assert property (##1 filt_cfg == {$past(filt_ff[5]), $past(filt_ff[4]), $past(filt_ff[3:2])})
        else $error("filter outputs do not follow register");
    a_cal_tail: assert property (@(posedge sclk) disable iff (!reset_n)
        cal_start_w |-> ##1 (!$changed(wr_tgl_ff)) [*4] ##1 $changed(wr_tgl_ff))
        else $error("calibration write not held four clocks");
    a_hdr_repeat: assert property (@(posedge sclk) disable iff (!reset_n)
        slot_end_w && !cs_n && hdr_w && !new_w && rpt_s_ff[1] |=> idx_ff == 4'h0 && tx_sh_ff[31:30] == 2'h3)
        else $error("not-ready header not repeated");

    c_auto_load: cover property (load_w && auto_w && !acq.pace_flag);
    c_skip_emit: cover property (emit_w && frm_ff[FRM_SKIP_LSB]);
    c_hdr_repeat: cover property (@(posedge sclk) slot_end_w && stay_w && rpt_s_ff[1]);
    c_cal_write: cover property (@(posedge sclk) cal_start_w);
endmodule : efc_frame_ctrl

// [logic/efc_pkg.sv]
// Constants, types and register map of the frame composition controller.
// Assumes a core clock of 10 MHz and a host that clocks the serial port.
//
// Behaviour
// - Bits 23, 22 and 21 each drop one of the three channel words from the frame when set.
// - A channel word still in the frame passes raw, so its content is undefined once that electrode is off.
// - Bits 14, 13, 11, 10 and 9 drop the pace, resp magnitude, electrode-off, pin state and check words; all reset to 0.
// - Bit 12 drops the resp phase word and resets to 1, so that word is absent until cleared.
// - Bit 7 drops the pace, resp magnitude and electrode-off words when their header flags are clear.
// - Bit 6 makes the port send only a not-ready header, again and again, until a frame is ready.
// - Bit 4 picks lead words (0, only at 2 kHz and 16 kHz) or electrode words (1).
// - Field [3:2] sends every frame (00), every second frame (01) or every fourth frame (1x).
// - Field [1:0] sets the frame rate: 2 kHz, 16 kHz, 128 kHz with electrode words, or 31.25 Hz.
// - Filter bit 5 inserts the master-port notch when 1 and bypasses it when 0.
// - Filter bit 4 bypasses the ordinary notch when 1 and keeps it when 0.
// - Filter field [3:2] sets the low-pass corner to 40, 150, 250 or 450 Hz.
package efc_pkg;
    // ==================================================
    // Register map
    localparam logic [6:0]  REG_CALIBRATION_CONVERTER_CTRL_OFS = 7'h09;
    localparam logic [6:0]  REG_FRAME_OFS  = 7'h0A;
    localparam logic [6:0]  REG_FILT_OFS   = 7'h0B;
    localparam logic [23:0] CALIBRATION_CONVERTER_CTRL_RST     = 24'h002000;
    localparam logic [23:0] FRAME_RST      = 24'h079000;
    localparam logic [23:0] FILT_RST       = 24'h000000;
    // ==================================================
    // Frame register fields
    localparam int FRM_CH1_EXCL   = 23;
    localparam int FRM_CH2_EXCL   = 22;
    localparam int FRM_CH3_EXCL   = 21;
    localparam int FRM_PACE_EXCL  = 14;
    localparam int FRM_RESPM_EXCL = 13;
    localparam int FRM_RESPP_EXCL = 12;
    localparam int FRM_EOFF_EXCL  = 11;
    localparam int FRM_PIN_EXCL   = 10;
    localparam int FRM_CHK_EXCL   = 9;
    localparam int FRM_AUTO_DROP  = 7;
    localparam int FRM_HDR_RPT    = 6;
    localparam int FRM_FORMAT     = 4;
    localparam int FRM_SKIP_LSB   = 2;
    localparam int FRM_RATE_LSB   = 0;
    // ==================================================
    // Filter register fields
    localparam int FILT_MASTER_NOTCH = 5;
    localparam int FILT_NOTCH_BYPASS = 4;
    localparam int FILT_LPF_LSB      = 2;
    // ==================================================
    // Serial command word and frame words
    localparam int CMD_WRITE_BIT = 31;
    localparam int CMD_ADDR_LSB  = 24;
    localparam int HDR_MARK_BIT  = 31;
    localparam int HDR_NRDY_BIT  = 30;
    localparam logic [31:0] HDR_NOT_READY = 32'hC0000000;
    localparam logic [7:0]  WA_CH1   = 8'h11;
    localparam logic [7:0]  WA_PACE  = 8'h1A;
    localparam logic [7:0]  WA_RESPM = 8'h1B;
    localparam logic [7:0]  WA_RESPP = 8'h1C;
    localparam logic [7:0]  WA_EOFF  = 8'h1D;
    localparam logic [7:0]  WA_PIN   = 8'h06;
    localparam logic [7:0]  WA_CHK   = 8'h41;
    localparam int          FRAME_WORDS = 10;
    localparam logic [2:0]  CAL_TAIL_SCLK = 3'h4;
    // ==================================================
    // Frame timing
    localparam longint CLK_HZ       = 64'd10_000_000;
    localparam longint RATE_2K_MHZ  = 64'd2_000_000;
    localparam longint RATE_16K_MHZ = 64'd16_000_000;
    localparam longint RATE_128K_MHZ = 64'd128_000_000;
    localparam longint RATE_SLOW_MHZ = 64'd31_250;
    localparam longint RATE_2K_CYC_DEF   = CLK_HZ * 64'd1000 / RATE_2K_MHZ;
    localparam longint RATE_16K_CYC      = CLK_HZ * 64'd1000 / RATE_16K_MHZ;
    localparam longint RATE_128K_CYC     = CLK_HZ * 64'd1000 / RATE_128K_MHZ;
    localparam longint RATE_SLOW_CYC_DEF = CLK_HZ * 64'd1000 / RATE_SLOW_MHZ;
    typedef enum logic [1:0] {
        RATE_2K   = 2'b00,
        RATE_16K  = 2'b01,
        RATE_128K = 2'b10,
        RATE_SLOW = 2'b11
    } efc_rate_e;
    // ==================================================
    // Carriers
    typedef struct packed {
        logic             pace_flag;
        logic             resp_flag;
        logic             eoff_flag;
        logic [2:0][23:0] chan;
        logic [23:0]      pace;
        logic [23:0]      resp_mag;
        logic [23:0]      resp_phase;
        logic [23:0]      eoff;
        logic [23:0]      pin_state;
    } efc_acq_s;
    typedef struct packed {
        logic       master_notch_insert;
        logic       notch_bypass;
        logic [1:0] lowpass_corner_select;
    } efc_filt_s;
endpackage : efc_pkg

// [verification/efc_frame_ctrl_tb.sv]
// Bench for the frame composition controller: registers, frame content, spacing.
// Assumes the host model owns the serial pins and acq stays steady.
module efc_frame_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import efc_pkg::*;
    typedef struct packed {
        logic [6:0]  a;
        logic [23:0] d;
        logic [3:0]  filt;
        logic        fmt;
    } efc_row_s;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    efc_acq_s    acq;
    wire         sclk;
    wire         cs_n;
    wire         mosi;
    wire         sdo;
    efc_filt_s   filt_cfg;
    logic [23:0] calibration_converter_ctrl_word;
    logic        electrode_fmt;
    int          mismatches = 0;
    int          checked = 0;
    logic [31:0] rx;
    logic [31:0] exp_q[$];
    int          n;
    efc_row_s    rows[11] = '{
        '{7'h0B, 24'h000020, 4'h8, 1'b0}, '{7'h0B, 24'h000010, 4'h4, 1'b0},
        '{7'h0B, 24'h00000C, 4'h3, 1'b0}, '{7'h0B, 24'h000004, 4'h1, 1'b0},
        '{7'h0B, 24'h000008, 4'h2, 1'b0}, '{7'h0C, 24'h00003C, 4'h2, 1'b0},
        '{7'h0A, 24'h1F8010, 4'h2, 1'b1}, '{7'h0A, 24'h1F8002, 4'h2, 1'b1},
        '{7'h0A, 24'h1F8003, 4'h2, 1'b1}, '{7'h0A, 24'h1F8001, 4'h2, 1'b0},
        '{7'h0A, 24'h1F9000, 4'h2, 1'b0}};
    logic [23:0] cfgs[5] = '{24'h5F8400, 24'hBF9200, 24'h1FAA00, 24'h1F90C0, 24'h1F9080};
    always #50 ref_clk = ~ref_clk;
    efc_host_model i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .sdo(sdo));
    efc_frame_ctrl #(.RATE_2K_CYC(200), .RATE_SLOW_CYC(2000)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .acq(acq),
        .sdo(sdo), .filt_cfg(filt_cfg), .calibration_converter_ctrl_word(calibration_converter_ctrl_word), .electrode_fmt(electrode_fmt));
    // ==================================================
    // Shared tasks
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [23:0] d, input int tail);
        i_host.slot({1'b1, a, d}, rx);
        i_host.stop(tail);
        repeat (6) @(posedge ref_clk);
        #5;
    endtask : wr
    // Slots up to and including the next ready header
    task automatic find_hdr(output int cnt);
        cnt = 0;
        do begin
            i_host.slot(32'h0, rx);
            cnt++;
        end while (rx[31:30] !== 2'b10 && cnt < 400);
        if (cnt >= 400) begin
            mismatches++;
            wrap_up();
        end
    endtask : find_hdr
    // Second header skips a frame built before the new setting landed
    task automatic frame_chk(input logic [23:0] f);
        logic [31:0] w[8];
        int          ex[8];
        logic [23:0] x;
        w = '{{8'h11, acq.chan[0]}, {8'h12, acq.chan[1]}, {8'h13, acq.chan[2]}, {8'h1A, acq.pace},
              {8'h1B, acq.resp_mag}, {8'h1C, acq.resp_phase}, {8'h1D, acq.eoff}, {8'h06, acq.pin_state}};
        ex = '{23, 22, 21, 14, 13, 12, 11, 10};
        x = 24'h0;
        exp_q = {};
        for (int i = 0; i < 8; i++) begin
            if (!f[ex[i]] && !(f[7] && ((i == 3 && !acq.pace_flag) || (i == 4 && !acq.resp_flag)
                || (i == 6 && !acq.eoff_flag)))) begin
                exp_q.push_back(w[i]);
                x ^= w[i][23:0];
            end
        end
        if (!f[9]) exp_q.push_back({8'h41, x});
        find_hdr(n);
        find_hdr(n);
        chk(rx & 32'hF8000000, {2'b10, acq.pace_flag, acq.resp_flag, acq.eoff_flag, 27'h0});
        foreach (exp_q[i]) begin
            i_host.slot(32'h0, rx);
            chk(rx, exp_q[i]);
        end
        i_host.slot(32'h0, rx);
        chk(rx, HDR_NOT_READY);
        i_host.slot(32'h0, rx);
        chk(rx, f[6] ? HDR_NOT_READY : 32'h0);
        i_host.stop(0);
    endtask : frame_chk
    // ==================================================
    // Main sequence
    initial begin
        acq = {1'b1, 1'b0, 1'b1, 24'h333333, 24'h222222, 24'h111111,
               24'hAAAAAA, 24'hBBBBBB, 24'hCCCCCC, 24'hDDDDDD, 24'h0F0F0F};
        repeat (2) @(posedge ref_clk);
        #5;
        chk(32'(calibration_converter_ctrl_word), 32'(CALIBRATION_CONVERTER_CTRL_RST));
        chk(32'(filt_cfg), 32'h0);
        reset_n = 1'b1;
        frame_chk(FRAME_RST);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 0);
            chk(32'(filt_cfg), 32'(rows[i].filt));
            chk(32'(electrode_fmt), 32'(rows[i].fmt));
        end
        foreach (cfgs[i]) begin
            wr(7'h0A, cfgs[i], 0);
            frame_chk(cfgs[i]);
        end
        // Header spacing grows with the skip field
        for (int s = 0; s < 3; s++) begin
            wr(7'h0A, 24'h1F9000 | 24'(s << 2), 0);
            // Skip phase settles only after one frame under the new setting
            find_hdr(n);
            find_hdr(n);
            find_hdr(n);
            i_host.stop(0);
            chk(32'(n > 36 * (1 << s) && n < 48 * (1 << s)), 32'h1);
        end
        wr(7'h09, 24'h0ABCDE, 4);
        chk(32'(calibration_converter_ctrl_word), 32'h0ABCDE);
        wr(7'h09, 24'h012345, 0);
        chk(32'(calibration_converter_ctrl_word), 32'h0ABCDE);
        #5 reset_n = 1'b0;
        #20;
        chk(32'(calibration_converter_ctrl_word), 32'(CALIBRATION_CONVERTER_CTRL_RST));
        chk(32'(electrode_fmt), 32'h0);
        wrap_up();
    end
    initial begin
        #3ms;
        mismatches++;
        wrap_up();
    end
endmodule : efc_frame_ctrl_tb

// [verification/efc_host_model.sv]
// Host side of the serial port: sends command words and collects frame words.
// Assumes the device samples mosi and shifts sdo on sclk rising edges.
module efc_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // ==================================================
    // Slot transfer
    // Sdo read mid low phase, well clear of its shift
    task automatic slot(input logic [31:0] cmd, output logic [31:0] rx);
        cs_n = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi = cmd[i];
            #3.5;
            rx[i] = sdo;
            #4 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
    endtask : slot
    // ==================================================
    // Burst end
    // Clock stands still outside bursts; tail edges finish a converter update
    task automatic stop(input int tail);
        repeat (tail) begin
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        mosi = ~mosi;
    endtask : stop
endmodule : efc_host_model
